// *** logic/rcs_pkg.sv ***
package rcs_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_CFG_ADDR    = 8'h00;
  localparam logic [7:0] REG_THRESH_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h08;
  localparam logic [7:0] REG_SLIP_ADDR   = 8'h0C;

  // ==========================================================
  // configuration fields
  localparam int CFG_BASIC_8B10B_BIT           = 0;
  localparam int CFG_PIPE_MODE_BIT             = 1;
  localparam int CFG_GIGABIT_ETHERNET_MODE_BIT = 2;
  localparam int CFG_MANUAL_ALIGN_BIT          = 3;
  localparam int CFG_IDLE_INFER_BIT            = 4;
  localparam int CFG_CORE_CLK_EN_BIT           = 5;
  localparam int CFG_WIDTH                     = 6;
  localparam logic [5:0] CFG_RESET             = 6'h00;
  localparam logic [5:0] THRESH_RESET          = 6'h04;
  localparam int SLIP_CMD_BIT                  = 0;

  // ==========================================================
  // status fields
  localparam int STS_LOCK_BIT     = 0;
  localparam int STS_SIGDET_BIT   = 1;
  localparam int STS_FIFOERR_BIT  = 2;
  localparam int STS_FULL_BIT     = 3;
  localparam int STS_EMPTY_BIT    = 4;
  localparam int STS_ELECIDLE_BIT = 5;
  localparam int STS_SLIP_LSB     = 8;

  // ==========================================================
  // word and timing
  localparam int WORD_BITS     = 10;
  localparam logic [3:0] SLIP_LAST = 4'h9;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REF_DWELL_NS  = 4000;
  localparam int REF_DWELL_CYC = (REF_DWELL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SIGDET_WIN_CYC = 64;

  // ==========================================================
  // lock state machine
  typedef enum logic [1:0] {
    LS_REF  = 2'b01,
    LS_DATA = 2'b10
  } rcs_lock_state_t;

endpackage

// *** logic/rcs_align_if.sv ***
`timescale 1ns/10ps
interface rcs_align_if;
  import rcs_pkg::*;
  logic                 serialBit;
  logic                 dataLocked;
  logic                 manualAlign;
  logic                 slipPulse;
  logic [WORD_BITS-1:0] word;
  logic                 wordValid;
  logic [3:0]           slipCount;

  modport aligner (input serialBit, dataLocked, manualAlign, slipPulse,
                   output word, wordValid, slipCount);
  modport ctrl    (output serialBit, dataLocked, manualAlign, slipPulse,
                   input word, wordValid, slipCount);
endinterface

// *** logic/rcs_word_aligner.sv ***
`timescale 1ns/10ps
module rcs_word_aligner
(
  // clock and reset
  input wire logic    ref_clk,
  input wire logic    reset_n,
  // link to the controller
  rcs_align_if.aligner al
);
  import rcs_pkg::*;

  logic [WORD_BITS-1:0] shift_ff;
  logic [3:0]           bitCnt_ff;
  logic [3:0]           slip_ff;
  logic [WORD_BITS-1:0] word_ff;
  logic                 valid_ff;
  logic                 doSlip;
  logic                 wordEnd;

  // ==========================================================
  // slip decode: only honoured in manual alignment
  assign doSlip  = al.slipPulse && al.manualAlign;
  assign wordEnd = (bitCnt_ff == 4'(WORD_BITS - 1)) && !doSlip;

  // a slip holds the bit counter one cycle, moving the boundary by one bit
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_ff  <= '0;
      bitCnt_ff <= 4'h0;
    end
    else if (al.dataLocked)
    begin
      shift_ff  <= {al.serialBit, shift_ff[WORD_BITS-1:1]};
      if (!doSlip)
        bitCnt_ff <= wordEnd ? 4'h0 : bitCnt_ff + 4'h1;
    end
  end

  // slip count wraps 9 -> 0; cleared outside manual mode
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      slip_ff <= 4'h0;
    else if (!al.manualAlign)
      slip_ff <= 4'h0;
    else if (doSlip)
      slip_ff <= (slip_ff == SLIP_LAST) ? 4'h0 : slip_ff + 4'h1;
  end

  // completed word, registered
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_ff  <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= al.dataLocked && wordEnd;
      if (al.dataLocked && wordEnd)
        word_ff <= {al.serialBit, shift_ff[WORD_BITS-1:1]};
    end
  end

  assign al.word      = word_ff;
  assign al.wordValid = valid_ff;
  assign al.slipCount = slip_ff;

endmodule // rcs_word_aligner

// *** logic/rcs_rx_cdr_status.sv ***
`timescale 1ns/10ps
// Summary of operation
// - optional core clock output for fifo reads
// - fifo error high when full or empty
// - manual alignment reports slips, 0 through 9
// - lock indicator high in data lock
// - force-data wins over force-reference
// - 00 auto, 01 reference, 1x data
// - signal detect when activity exceeds threshold
// - detect only basic 8b10b or pipe
// - recovered clock only in gigabit ethernet
// - pipe without inference: idle is inverted detect
module rcs_rx_cdr_status
#(
  parameter int FIFO_DEPTH = 4,
  parameter int DWELL_CYC  = rcs_pkg::REF_DWELL_CYC,
  parameter int WIN_CYC    = rcs_pkg::SIGDET_WIN_CYC
)
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // serial line
  input  wire logic                          rxSerialIn,
  // lock controls from fabric
  input  wire logic                          forceLockToData,
  input  wire logic                          forceLockToRef,
  // status to fabric
  output logic                               lockStateOut,
  output logic                               signalDetectOut,
  output logic                               elecIdleOut,
  output logic [3:0]                         slip_count_out,
  // phase compensation fifo
  input  wire logic                          rxFifoRd,
  output logic [rcs_pkg::WORD_BITS-1:0]      rxDataOut,
  output logic                               rxDataValid,
  output logic                               phaseFifoErr,
  // clocks out
  output logic                               rxCoreClkOut,
  output logic                               recovClkOut,
  // register port
  input  wire logic [7:0]                    regAddr,
  input  wire logic [31:0]                   regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [31:0]                        regRdData
);
  import rcs_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int DW = $clog2(DWELL_CYC + 1);
  localparam int WW = $clog2(WIN_CYC);

  rcs_align_if al();

  logic [CFG_WIDTH-1:0]  cfg_ff;
  logic [5:0]            thresh_ff;
  logic [31:0]           rdData_ff;
  rcs_lock_state_t       lock_ff;
  rcs_lock_state_t       nxt_lock;
  logic [DW-1:0]         dwell_ff;
  logic [WW-1:0]         win_ff;
  logic [6:0]            edges_ff;
  logic                  prevBit_ff;
  logic                  actRaw_ff;
  logic                  quietRaw_ff;
  logic                  sigDet_ff;
  logic                  idle_ff;
  logic                  lockOut_ff;
  logic [WORD_BITS-1:0]  mem [FIFO_DEPTH];
  logic [PW-1:0]         wrPtr_ff;
  logic [PW-1:0]         rdPtr_ff;
  logic [CW-1:0]         count_ff;
  logic [WORD_BITS-1:0]  dout_ff;
  logic                  doutValid_ff;
  logic                  fifoErr_ff;
  logic [3:0]            coreDiv_ff;
  logic                  coreClk_ff;
  logic [3:0]            recDiv_ff;
  logic                  recClk_ff;

  // ==========================================================
  // register decode
  wire selCfg     = (regAddr == REG_CFG_ADDR);
  wire selThresh  = (regAddr == REG_THRESH_ADDR);
  wire selStatus  = (regAddr == REG_STATUS_ADDR);
  wire selSlip    = (regAddr == REG_SLIP_ADDR);
  wire modeBasic  = cfg_ff[CFG_BASIC_8B10B_BIT];
  wire modePipe   = cfg_ff[CFG_PIPE_MODE_BIT];
  wire gigabit_ethernet_mode = cfg_ff[CFG_GIGABIT_ETHERNET_MODE_BIT];
  wire idleInfer  = cfg_ff[CFG_IDLE_INFER_BIT];
  wire fifoFull   = (count_ff == CW'(FIFO_DEPTH));
  wire fifoEmpty  = (count_ff == '0);
  wire fifoWr     = al.wordValid && !fifoFull;   // words beyond full are dropped
  wire fifoRdOk   = rxFifoRd && !fifoEmpty;
  wire edgeSeen   = rxSerialIn != prevBit_ff;
  wire winEnd     = (win_ff == WW'(WIN_CYC - 1));
  wire dwellDone  = (dwell_ff == DW'(DWELL_CYC));

  // config and threshold registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ff    <= CFG_RESET;
      thresh_ff <= THRESH_RESET;
    end
    else if (regWr)
    begin
      if (selCfg)
        cfg_ff <= regWrData[CFG_WIDTH-1:0];
      if (selThresh)
        thresh_ff <= regWrData[5:0];
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  wire [31:0] statusWord = {
    20'h00000,
    slip_count_out,
    2'b00,
    idle_ff,
    fifoEmpty,
    fifoFull,
    fifoErr_ff,
    sigDet_ff,
    lockOut_ff
  };
  wire [31:0] rdMux = selCfg    ? {26'h0000000, cfg_ff} :
                      selThresh ? {26'h0000000, thresh_ff} :
                      selStatus ? statusWord : 32'h00000000;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData_ff <= 32'h00000000;
    else
      rdData_ff <= regRd ? rdMux : 32'h00000000;
  end

  assign regRdData = rdData_ff;

  // ==========================================================
  // signal activity: edges counted over a window
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prevBit_ff  <= 1'b0;
      win_ff      <= '0;
      edges_ff    <= 7'h00;
      actRaw_ff   <= 1'b0;
      quietRaw_ff <= 1'b1;
    end
    else
    begin
      prevBit_ff <= rxSerialIn;                      // far end drives the line
      win_ff     <= winEnd ? '0 : win_ff + WW'(1);
      edges_ff   <= winEnd ? 7'h00 : edges_ff + {6'h00, edgeSeen};
      if (winEnd)
      begin
        actRaw_ff   <= edges_ff > {1'b0, thresh_ff};
        quietRaw_ff <= (edges_ff == 7'h00);
      end
    end
  end

  // detect only offered in basic 8b10b or pipe; idle only in pipe, inverse of detect unless inferred
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sigDet_ff <= 1'b0;
      idle_ff   <= 1'b0;
    end
    else
    begin
      sigDet_ff <= actRaw_ff && (modeBasic || modePipe);
      if (!modePipe)
        idle_ff <= 1'b0;
      else if (idleInfer)
        idle_ff <= quietRaw_ff;
      else
        idle_ff <= !(actRaw_ff);
    end
  end

  // ==========================================================
  // lock mode decode and state
  always_comb
  begin
    nxt_lock = lock_ff;
    if (forceLockToData)                      // 1x forces data lock
      nxt_lock = LS_DATA;
    else if (forceLockToRef)                  // 01 manual reference
      nxt_lock = LS_REF;
    else
    begin
      unique case (lock_ff)                   // 00 automatic
        LS_REF:  if (dwellDone && actRaw_ff) nxt_lock = LS_DATA;
        LS_DATA: if (!actRaw_ff) nxt_lock = LS_REF;
      endcase
    end
  end

  // dwell restarts on every entry to reference lock
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_ff    <= LS_REF;
      dwell_ff   <= '0;
      lockOut_ff <= 1'b0;
    end
    else
    begin
      lock_ff    <= nxt_lock;
      lockOut_ff <= (nxt_lock == LS_DATA);
      if (nxt_lock != LS_REF)
        dwell_ff <= '0;
      else if (!dwellDone)
        dwell_ff <= dwell_ff + DW'(1);
    end
  end

  // ==========================================================
  // aligner hookup; a slip command is a write to the slip register
  assign al.serialBit   = rxSerialIn;
  assign al.dataLocked  = (lock_ff == LS_DATA);
  assign al.manualAlign = cfg_ff[CFG_MANUAL_ALIGN_BIT];
  assign al.slipPulse   = regWr && selSlip && regWrData[SLIP_CMD_BIT];

  rcs_word_aligner u_align
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .al      (al.aligner)
  );

  // ==========================================================
  // phase compensation fifo
  always_ff @(posedge ref_clk)
  begin
    if (fifoWr)
      mem[wrPtr_ff] <= al.word;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr_ff     <= '0;
      rdPtr_ff     <= '0;
      count_ff     <= '0;
      dout_ff      <= '0;
      doutValid_ff <= 1'b0;
    end
    else
    begin
      if (fifoWr)
        wrPtr_ff <= (wrPtr_ff == PW'(FIFO_DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      if (fifoRdOk)
      begin
        rdPtr_ff <= (rdPtr_ff == PW'(FIFO_DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
        dout_ff  <= mem[rdPtr_ff];
      end
      doutValid_ff <= fifoRdOk;
      count_ff <= count_ff + CW'(fifoWr) - CW'(fifoRdOk);
    end
  end

  // error flag covers both full and empty, recomputed each cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      fifoErr_ff <= 1'b1;
    else
      fifoErr_ff <= (count_ff + CW'(fifoWr) - CW'(fifoRdOk) == CW'(FIFO_DEPTH)) ||
                    (count_ff + CW'(fifoWr) - CW'(fifoRdOk) == '0);
  end

  // ==========================================================
  // clock outputs, both divided by the word length
  // registered so no output can glitch; a core pulse is never cut short
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      coreDiv_ff <= 4'h0;
      coreClk_ff <= 1'b0;
      recDiv_ff  <= 4'h0;
      recClk_ff  <= 1'b0;
    end
    else
    begin
      coreDiv_ff <= (coreDiv_ff == 4'(WORD_BITS - 1)) ? 4'h0 : coreDiv_ff + 4'h1;
      // the enable is only looked at in phase zero, so a pulse runs its full half
      coreClk_ff <= (coreDiv_ff == 4'h0) ? cfg_ff[CFG_CORE_CLK_EN_BIT] :
                    (coreClk_ff && (coreDiv_ff < 4'(WORD_BITS / 2)));
      // recovered phase realigns to each word from the line
      recDiv_ff  <= al.wordValid ? 4'h1 :
                    (recDiv_ff == 4'(WORD_BITS - 1)) ? 4'h0 : recDiv_ff + 4'h1;
      recClk_ff  <= gigabit_ethernet_mode && al.dataLocked &&
                    (recDiv_ff < 4'(WORD_BITS / 2));
    end
  end

  // ==========================================================
  // outputs
  assign lockStateOut    = lockOut_ff;
  assign signalDetectOut = sigDet_ff;
  assign elecIdleOut     = idle_ff;
  assign slip_count_out  = al.slipCount;
  assign rxDataOut       = dout_ff;
  assign rxDataValid     = doutValid_ff;
  assign phaseFifoErr    = fifoErr_ff;
  assign rxCoreClkOut    = coreClk_ff;
  assign recovClkOut     = recClk_ff;

endmodule // rcs_rx_cdr_status

// *** dv/rcs_rx_cdr_status_checker.sv ***
`timescale 1ns/10ps
// ==========
// port checker
module rcs_rx_cdr_status_checker
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // lock
  input wire logic        forceLockToData,
  input wire logic        forceLockToRef,
  input wire logic        lockStateOut,
  // status
  input wire logic        signalDetectOut,
  input wire logic        elecIdleOut,
  input wire logic [3:0]  slip_count_out,
  input wire logic        rxFifoRd,
  input wire logic        rxDataValid,
  input wire logic        rxCoreClkOut,
  input wire logic        recovClkOut,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr
);
  import rcs_pkg::*;
  logic [5:0] cfgShadow_ff;
  logic [5:0] nxt_cfgShadow;
  logic       pipeNoInfer;
  logic       detMode;
  logic       recovOk;
  logic       manualOn;
  // shadow of the mode register, since the mode bits never reach a pin
  assign nxt_cfgShadow = (regWr && regAddr == REG_CFG_ADDR) ? regWrData[5:0] : cfgShadow_ff;
  assign pipeNoInfer = cfgShadow_ff[CFG_PIPE_MODE_BIT] & ~cfgShadow_ff[CFG_IDLE_INFER_BIT];
  assign detMode = cfgShadow_ff[CFG_PIPE_MODE_BIT] | cfgShadow_ff[CFG_BASIC_8B10B_BIT];
  assign recovOk = cfgShadow_ff[CFG_GIGABIT_ETHERNET_MODE_BIT] & lockStateOut;
  assign manualOn = cfgShadow_ff[CFG_MANUAL_ALIGN_BIT];
  // shadow register
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      cfgShadow_ff <= CFG_RESET;
    else
      cfgShadow_ff <= nxt_cfgShadow;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // properties
  lock_data_a: assert property (forceLockToData [*3] |-> lockStateOut)
    else $error("lock not data under data force");
  lock_ref_a: assert property ((!forceLockToData && forceLockToRef) [*3] |-> !lockStateOut)
    else $error("lock not reference under reference force");
  slip_range_a: assert property (slip_count_out <= SLIP_LAST)
    else $error("slip count above nine");
  slip_zero_a: assert property (!manualOn [*3] |-> slip_count_out == 4'h0)
    else $error("slip count outside manual mode");
  valid_cause_a: assert property (rxDataValid |-> $past(rxFifoRd))
    else $error("fifo data without read");
  idle_inv_a: assert property ((pipeNoInfer && $stable(signalDetectOut)) [*3] |-> elecIdleOut == !signalDetectOut)
    else $error("idle not inverse of detect");
  det_mode_a: assert property (!detMode [*3] |-> !signalDetectOut)
    else $error("detect outside its modes");
  recov_mode_a: assert property (!recovOk [*3] |-> !recovClkOut)
    else $error("recovered clock outside ethernet data lock");
  core_clk_a: assert property ($rose(rxCoreClkOut) |-> rxCoreClkOut [*5] ##1 !rxCoreClkOut)
    else $error("core clock high phase wrong");
endmodule // rcs_rx_cdr_status_checker

bind rcs_rx_cdr_status rcs_rx_cdr_status_checker i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .forceLockToData(forceLockToData),
  .forceLockToRef(forceLockToRef), .lockStateOut(lockStateOut),
  .signalDetectOut(signalDetectOut), .elecIdleOut(elecIdleOut),
  .slip_count_out(slip_count_out), .rxFifoRd(rxFifoRd), .rxDataValid(rxDataValid),
  .rxCoreClkOut(rxCoreClkOut), .recovClkOut(recovClkOut), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr));

// *** dv/rcs_line_source.sv ***
`timescale 1ns/10ps
// ==========
// far end transmitter: toggles every bit while on, flat line when idle
module rcs_line_source
(
  // clock
  input wire logic ref_clk,
  // control
  input wire logic srcOn,
  // serial line
  output logic     rxSerialIn
);
  logic bit_ff = 1'b0;
  // idle is a flat level so that the activity count really drops
  always @(posedge ref_clk)
    bit_ff <= srcOn ? ~bit_ff : 1'b0;
  assign rxSerialIn = bit_ff;
endmodule // rcs_line_source

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    cmpCount++; \
    if ((e) !== (g)) \
    begin \
      numErrors++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end
// ==========
// top of the bench
module testbench;
  import rcs_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, srcOn = 1'b0, rxSerialIn;
  logic forceLockToData = 1'b0, forceLockToRef = 1'b0, rxFifoRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, mExp, mMsk, rnd;
  logic regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0, lockStateOut, signalDetectOut;
  logic elecIdleOut, rxDataValid, phaseFifoErr, rxCoreClkOut, recovClkOut;
  logic [3:0] slip_count_out;
  logic [WORD_BITS-1:0] rxDataOut;
  logic [31:0] expQ[$], mskQ[$];
  string nameQ[$], mName;
  int numErrors = 0, cmpCount = 0, validCnt = 0, seed = 26, k;
  always #2 ref_clk = ~ref_clk;
  rcs_line_source i_rcs_line_source (.ref_clk(ref_clk), .srcOn(srcOn), .rxSerialIn(rxSerialIn));
  // short dwell and window keep the run brief
  rcs_rx_cdr_status #(.DWELL_CYC(20), .WIN_CYC(8)) i_rcs_rx_cdr_status (
    .ref_clk(ref_clk), .reset_n(reset_n), .rxSerialIn(rxSerialIn),
    .forceLockToData(forceLockToData), .forceLockToRef(forceLockToRef),
    .lockStateOut(lockStateOut), .signalDetectOut(signalDetectOut),
    .elecIdleOut(elecIdleOut), .slip_count_out(slip_count_out), .rxFifoRd(rxFifoRd),
    .rxDataOut(rxDataOut), .rxDataValid(rxDataValid), .phaseFifoErr(phaseFifoErr),
    .rxCoreClkOut(rxCoreClkOut), .recovClkOut(recovClkOut), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  // ==========
  // tasks
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  // a read leaves its note for the monitor
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e & m);
    mskQ.push_back(m);
    nameQ.push_back(nm);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask
  task lock(input logic [1:0] c);
    @(posedge ref_clk);
    {forceLockToData, forceLockToRef} <= c;
  endtask
  task pop;
    @(posedge ref_clk);
    rxFifoRd <= 1'b1;
    @(posedge ref_clk);
    rxFifoRd <= 1'b0;
  endtask
  function logic probe(input int s);
    case (s)
      0: return lockStateOut;
      1: return signalDetectOut;
      2: return phaseFifoErr;
      4: return elecIdleOut;
      default: return recovClkOut;
    endcase
  endfunction
  // bounded wait; running out counts a mismatch and ends the run
  task wait_on(input int s, input logic lvl, input int lim);
    for (int n = 0; n < lim; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (probe(s) === lvl)
        return;
    end
    numErrors++;
    $display("BAD wait%0d exp %0h got timeout", s, lvl);
    give_verdict();
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // monitor: read data stand only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rdPend)
    begin
      mName = nameQ.pop_front();
      mExp = expQ.pop_front();
      mMsk = mskQ.pop_front();
      `CHK(mName, mExp, regRdData & mMsk)
    end
    // an alternating line gives one of two words, whatever the phase
    if (rxDataValid === 1'b1)
    begin
      validCnt++;
      `CHK("word", 1'b1, rxDataOut == 10'h155 || rxDataOut == 10'h2AA)
    end
    rdPend <= regRd;
  end
  // ==========
  // main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    `CHK("fifoErr", 1'b1, phaseFifoErr)
    rd(REG_CFG_ADDR, 32'h0, '1, "cfg");
    rd(REG_THRESH_ADDR, 32'(THRESH_RESET), '1, "thresh");
    rd(REG_STATUS_ADDR, 32'h14, 32'h1D, "status");
    wr(REG_STATUS_ADDR, '1);
    rd(REG_STATUS_ADDR, 32'h14, 32'h1D, "status");
    rd(8'h10, 32'h0, '1, "unmapped");
    rnd = $random(seed);
    wr(REG_CFG_ADDR, rnd & 32'h1F);
    rd(REG_CFG_ADDR, rnd & 32'h1F, '1, "cfg");
    rnd = $random(seed);
    wr(REG_THRESH_ADDR, rnd & 32'h3F);
    rd(REG_THRESH_ADDR, rnd & 32'h3F, '1, "thresh");
    wr(REG_THRESH_ADDR, 32'h4);
    wr(REG_CFG_ADDR, 32'h0);
    // fill the fifo in data lock, then drain it past empty
    srcOn <= 1'b1;
    lock(2'b10);
    wait_on(2, 1'b0, 100);
    wait_on(2, 1'b1, 200);
    rd(REG_STATUS_ADDR, 32'h0C, 32'h1C, "full");
    lock(2'b01);
    repeat (12) @(posedge ref_clk);
    pop();
    @(posedge ref_clk);
    #1;
    `CHK("fifoErr", 1'b0, phaseFifoErr)
    repeat (4) pop();
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("valids", 4, validCnt)
    rd(REG_STATUS_ADDR, 32'h14, 32'h1C, "empty");
    // every force code, then automatic
    for (k = 1; k < 4; k++)
    begin
      lock(k[1:0]);
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK("lock", k[1], lockStateOut)
    end
    // automatic mode is entered from reference lock so its dwell shows
    wr(REG_CFG_ADDR, 32'h1);
    lock(2'b01);
    lock(2'b00);
    @(posedge ref_clk);
    #1;
    `CHK("lock", 1'b0, lockStateOut)
    wait_on(0, 1'b1, 400);
    wait_on(1, 1'b1, 100);
    rd(REG_STATUS_ADDR, 32'h2, 32'h2, "sigdet");
    @(posedge ref_clk);
    srcOn <= 1'b0;
    wait_on(1, 1'b0, 100);
    wr(REG_CFG_ADDR, 32'h2);
    @(posedge ref_clk);
    srcOn <= 1'b1;
    wait_on(1, 1'b1, 100);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("idle", 1'b0, elecIdleOut)
    // inferred idle: a flat line must raise the idle output
    wr(REG_CFG_ADDR, 32'h12);
    srcOn <= 1'b0;
    wait_on(4, 1'b1, 100);
    srcOn <= 1'b1;
    wait_on(1, 1'b1, 100);
    wr(REG_CFG_ADDR, 32'h0);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("sigdet", 1'b0, signalDetectOut)
    // slips wrap after nine
    lock(2'b10);
    wr(REG_CFG_ADDR, 32'h8);
    for (k = 1; k < 11; k++)
    begin
      wr(REG_SLIP_ADDR, 32'h1);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("slip", 4'(k % 10), slip_count_out)
    end
    wr(REG_CFG_ADDR, 32'h24);
    wait_on(3, 1'b1, 100);
    repeat (30) @(posedge ref_clk);
    give_verdict();
  end
endmodule // testbench
